// ### design/rwd_irq_status.sv
// Sticky interrupt status with read-to-clear and mask, one level output.
`timescale 1ns/1ps
`default_nettype none
module rwd_irq_status #(
  parameter int unsigned W = 2
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // Events, clear and mask.
  input  wire logic [W-1:0] set_evt,
  input  wire logic         rd_clr,
  input  wire logic [W-1:0] mask,
  // Status and interrupt.
  output logic      [W-1:0] status,
  output logic              irq
);
  logic [W-1:0] status_reg, status_next;

  always_comb begin
    status_next = (status_reg & ~{W{rd_clr}}) | set_evt;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;
  assign irq    = |(status_reg & mask);
endmodule // rwd_irq_status
`default_nettype wire

// ### design/rwd_pkg.sv
// Shared constants of the runaway watchdog: register map, fields, resets, counts.
`default_nettype none
package rwd_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [31:0] ADDR_WDT_CTRL   = 32'h0000_7f0c;
  localparam logic [31:0] ADDR_BT_CTRL    = 32'h0000_7f10;
  localparam logic [31:0] ADDR_BT_CLKSEL  = 32'h0000_7f14;
  localparam logic [31:0] ADDR_INT_STATUS = 32'h0000_7f18;
  localparam logic [31:0] ADDR_INT_MASK   = 32'h0000_7f1c;
  localparam logic [31:0] ADDR_WDT_STATE  = 32'h0000_7f20;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_RUNAWAY   = 1;
  localparam int unsigned CTRL_HOLD_STOP = 3;
  localparam int unsigned CTRL_RST_FLAG  = 4;
  localparam int unsigned CTRL_RST_MODE  = 5;
  localparam int unsigned BT_RUN       = 0;
  localparam int unsigned BT_OSC_EN    = 1;
  localparam int unsigned BT_FAST      = 2;
  localparam int unsigned BT_CNT_LO    = 3;
  localparam int unsigned INT_RUNAWAY  = 0;
  localparam int unsigned INT_WRST     = 1;
  localparam int unsigned INT_W        = 2;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [4:0]  BT_RESET     = 5'h00;
  localparam logic [2:0]  CLKSEL_RESET = 3'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h0;
  localparam logic [23:0] RUNAWAY_VECTOR = 24'h008000;
  // ****************************************
  // Timing counts
  // ****************************************
  localparam int unsigned BT_SHORT_COUNT = 32;
  localparam int unsigned BT_LONG_COUNT  = 8192;
  localparam logic [2:0]  WDT_CNT_LAST   = 3'h7;
  localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
endpackage
`default_nettype wire

// ### design/rwd_tick_div.sv
// Base clock divider and base timer period counter producing watchdog ticks.
`timescale 1ns/1ps
`default_nettype none
module rwd_tick_div #(
  parameter int unsigned LONG_COUNT = rwd_pkg::BT_LONG_COUNT
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Settings in, ticks out.
  rwd_tick_if.div  tk
);
  logic [6:0]  pre_reg, pre_next, pre_last;
  logic [12:0] bt_reg, bt_next, bt_last;
  logic        tick_reg, tick_next, out_reg, out_next, active;

  always_comb begin
    active    = tk.bt_run && tk.osc_en;
    pre_last  = 7'((8'h01 << tk.clk_sel) - 8'h01);
    if (tk.fast && !tk.cnt_sel[1]) begin
      bt_last = 13'(rwd_pkg::BT_SHORT_COUNT - 1);
    end else begin
      bt_last = 13'(LONG_COUNT - 1);
    end
    pre_next  = pre_reg;
    bt_next   = bt_reg;
    tick_next = 1'b0;
    out_next  = 1'b0;
    if (!active) begin
      pre_next = 7'h00;
      bt_next  = 13'h0000;
    end else begin
      if (pre_reg >= pre_last) begin
        pre_next  = 7'h00;
        tick_next = 1'b1;
      end else begin
        pre_next = pre_reg + 7'h01;
      end
      if (tick_reg) begin
        if (bt_reg >= bt_last) begin
          bt_next  = 13'h0000;
          out_next = 1'b1;
        end else begin
          bt_next = bt_reg + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg  <= 7'h00;
      bt_reg   <= 13'h0000;
      tick_reg <= 1'b0;
      out_reg  <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      bt_reg   <= bt_next;
      tick_reg <= tick_next;
      out_reg  <= out_next;
    end
  end

  assign tk.base_tick = tick_reg;
  assign tk.bt_out    = out_reg;
endmodule // rwd_tick_div
`default_nettype wire

// ### design/rwd_tick_if.sv
// Interface carrying base timer settings and ticks between watchdog modules.
`timescale 1ns/1ps
`default_nettype none
interface rwd_tick_if;
  logic [2:0] clk_sel;
  logic       bt_run;
  logic       osc_en;
  logic       fast;
  logic [1:0] cnt_sel;
  logic       base_tick;
  logic       bt_out;
  modport div (input clk_sel, bt_run, osc_en, fast, cnt_sel, output base_tick, bt_out);
  modport ctl (output clk_sel, bt_run, osc_en, fast, cnt_sel, input base_tick, bt_out);
endinterface
`default_nettype wire

// ### design/rwd_watchdog.sv
// Runaway watchdog timer top: AHB-Lite registers, counter, overflow actions.
//
// Summary of operation
// - Once started, the counter steps up on each base timer output tick.
// - Counter overflow requests a reset or an interrupt, chosen by mode bit.
// - While running, only bit-clearing start clears the counter to zero.
// - Interrupt-mode overflow sets the runaway flag in the control register; reset-mode overflow clears it.
// - Mode bit 1 resets; mode bit 0 interrupts with vector 8000H.
// - Fast bit 1 with count select 00 or 01 gives 32 times 8 base periods.
// - Every other fast and count setting gives 8192 times 8 base periods.
// - Timeout is measured in base clock periods picked by the clock select.
// - After start, control writes are ignored except the counter clear.
// - Hold entry with hold-stop set clears start and stops the watchdog.
// - Starting with base timer stopped or oscillator off forces a reset.
// - A watchdog reset sets the reset flag, which that reset keeps.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rwd_watchdog #(
  parameter int unsigned LONG_COUNT = rwd_pkg::BT_LONG_COUNT
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // CPU events.
  input  wire logic        hold_enter,
  input  wire logic        reset_instr,
  // Watchdog actions.
  output logic             wdt_reset,
  output logic             wdt_int_req,
  output logic [23:0]      int_vector,
  output logic             irq
);
  // ****************************************
  // Declarations
  // ****************************************
  rwd_tick_if tk ();

  logic [5:0]  ctrl_reg, ctrl_next;
  logic [4:0]  bt_reg, bt_next;
  logic [2:0]  clksel_reg, clksel_next;
  logic [1:0]  mask_reg, mask_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        wrst_reg, wrst_next;
  logic        intr_reg, intr_next;
  logic [23:0] vec_reg, vec_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        dpw_reg, dpw_next;
  logic [31:0] dpa_reg, dpa_next;
  logic [1:0]  int_status;
  logic [1:0]  int_set;
  logic        ap_take, ap_read, rd_status;
  logic        wr_ctrl, wr_bt, wr_clksel, wr_mask;
  logic        started, running, clr_op, bad_start;
  logic        ovf_evt, ovf_rst, ovf_int;
  logic [31:0] rd_mux;

  // ****************************************
  // Base timer ticks and interrupt status
  // ****************************************
  rwd_tick_div #(
    .LONG_COUNT (LONG_COUNT)
  ) u_div (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tk      (tk)
  );

  assign tk.bt_run  = bt_reg[rwd_pkg::BT_RUN];
  assign tk.osc_en  = bt_reg[rwd_pkg::BT_OSC_EN];
  assign tk.fast    = bt_reg[rwd_pkg::BT_FAST];
  assign tk.cnt_sel = bt_reg[rwd_pkg::BT_CNT_LO +: 2];
  assign tk.clk_sel = clksel_reg;

  rwd_irq_status #(
    .W (rwd_pkg::INT_W)
  ) u_irq (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .set_evt (int_set),
    .rd_clr  (rd_status),
    .mask    (mask_reg),
    .status  (int_status),
    .irq     (irq)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  always_comb begin
    ap_take   = hsel && hready && (htrans[1] != 1'b0);
    ap_read   = ap_take && !hwrite;
    rd_status = ap_read && (haddr == rwd_pkg::ADDR_INT_STATUS);
    dpw_next  = ap_take && hwrite;
    dpa_next  = ap_take ? haddr : dpa_reg;
    wr_ctrl   = 1'b0;
    wr_bt     = 1'b0;
    wr_clksel = 1'b0;
    wr_mask   = 1'b0;
    if (dpw_reg && (dpa_reg == rwd_pkg::ADDR_WDT_CTRL)) begin
      wr_ctrl = 1'b1;
    end else if (dpw_reg && (dpa_reg == rwd_pkg::ADDR_BT_CTRL)) begin
      wr_bt = 1'b1;
    end else if (dpw_reg && (dpa_reg == rwd_pkg::ADDR_BT_CLKSEL)) begin
      wr_clksel = 1'b1;
    end else if (dpw_reg && (dpa_reg == rwd_pkg::ADDR_INT_MASK)) begin
      wr_mask = 1'b1;
    end
    rd_mux = 32'h0000_0000;
    if (haddr == rwd_pkg::ADDR_WDT_CTRL) begin
      rd_mux = {26'h000_0000, ctrl_reg};
    end else if (haddr == rwd_pkg::ADDR_BT_CTRL) begin
      rd_mux = {27'h000_0000, bt_reg};
    end else if (haddr == rwd_pkg::ADDR_BT_CLKSEL) begin
      rd_mux = {29'h000_0000, clksel_reg};
    end else if (haddr == rwd_pkg::ADDR_INT_STATUS) begin
      rd_mux = {30'h000_0000, int_status};
    end else if (haddr == rwd_pkg::ADDR_INT_MASK) begin
      rd_mux = {30'h000_0000, mask_reg};
    end else if (haddr == rwd_pkg::ADDR_WDT_STATE) begin
      rd_mux = {28'h000_0000, running, cnt_reg};
    end
    rdata_next = ap_read ? rd_mux : 32'h0000_0000;
  end

  // ****************************************
  // Watchdog control and counter
  // ****************************************
  always_comb begin
    started   = ctrl_reg[rwd_pkg::CTRL_START];
    running   = started && tk.bt_run;
    // Only the bit-clear pattern of start counts as a clear.
    clr_op    = wr_ctrl && started && !hwdata[0] && (hwdata[5:1] == ctrl_reg[5:1]);
    bad_start = wr_ctrl && !started && hwdata[0] && !(tk.bt_run && tk.osc_en);
    ovf_evt   = running && tk.bt_out && (cnt_reg == rwd_pkg::WDT_CNT_LAST) && !clr_op;
    ovf_rst   = ovf_evt && ctrl_reg[rwd_pkg::CTRL_RST_MODE];
    ovf_int   = ovf_evt && !ctrl_reg[rwd_pkg::CTRL_RST_MODE];
    ctrl_next = ctrl_reg;
    if (wr_ctrl && !started) begin
      ctrl_next = hwdata[5:0];
    end
    if (bad_start || ovf_rst) begin
      ctrl_next[rwd_pkg::CTRL_RST_FLAG] = 1'b1;
      ctrl_next[rwd_pkg::CTRL_RUNAWAY]  = 1'b0;
      ctrl_next[rwd_pkg::CTRL_START]    = 1'b0;
    end
    if (hold_enter && ctrl_reg[rwd_pkg::CTRL_HOLD_STOP]) begin
      ctrl_next[rwd_pkg::CTRL_START] = 1'b0;
    end
    if (reset_instr) begin
      ctrl_next[rwd_pkg::CTRL_RUNAWAY] = 1'b0;
      ctrl_next[rwd_pkg::CTRL_START]   = 1'b0;
    end
    if (ovf_int) begin
      ctrl_next[rwd_pkg::CTRL_RUNAWAY] = 1'b1;
    end
    cnt_next = cnt_reg;
    if (!started || clr_op) begin
      cnt_next = 3'h0;
    end else if (running && tk.bt_out) begin
      cnt_next = cnt_reg + 3'h1;
    end
    wrst_next = ovf_rst || bad_start;
    intr_next = ovf_int;
    vec_next  = ovf_int ? rwd_pkg::RUNAWAY_VECTOR : vec_reg;
    int_set   = {wrst_next, ovf_int};
  end

  // ****************************************
  // Software settings
  // ****************************************
  always_comb begin
    bt_next     = wr_bt ? hwdata[4:0] : bt_reg;
    clksel_next = wr_clksel ? hwdata[2:0] : clksel_reg;
    mask_next   = wr_mask ? hwdata[1:0] : mask_reg;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= rwd_pkg::CTRL_RESET;
      bt_reg     <= rwd_pkg::BT_RESET;
      clksel_reg <= rwd_pkg::CLKSEL_RESET;
      mask_reg   <= rwd_pkg::MASK_RESET;
      cnt_reg    <= 3'h0;
      wrst_reg   <= 1'b0;
      intr_reg   <= 1'b0;
      vec_reg    <= 24'h000000;
      rdata_reg  <= 32'h0000_0000;
      dpw_reg    <= 1'b0;
      dpa_reg    <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      bt_reg     <= bt_next;
      clksel_reg <= clksel_next;
      mask_reg   <= mask_next;
      cnt_reg    <= cnt_next;
      wrst_reg   <= wrst_next;
      intr_reg   <= intr_next;
      vec_reg    <= vec_next;
      rdata_reg  <= rdata_next;
      dpw_reg    <= dpw_next;
      dpa_reg    <= dpa_next;
    end
  end

  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = rdata_reg;
  assign wdt_reset   = wrst_reg;
  assign wdt_int_req = intr_reg;
  assign int_vector  = vec_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_last_tick;
    running && tk.bt_out && (cnt_reg == 3'h7) && !clr_op;
  endsequence

  sequence s_reset_action;
    wdt_reset && ctrl_reg[4] && !ctrl_reg[0] && !ctrl_reg[1];
  endsequence

  sequence s_good_start;
    wr_ctrl && !started && hwdata[0] && tk.bt_run && tk.osc_en && !hold_enter && !reset_instr;
  endsequence

  cnt_step_a: assert property (
    (running && tk.bt_out && !clr_op && !reset_instr && !hold_enter && cnt_reg != 3'h7)
    |=> (cnt_reg == $past(cnt_reg) + 3'h1))
    else $error("Counter did not step on a base timer tick.");

  wrap_ovf_a: assert property (
    s_last_tick |=> (wdt_reset || wdt_int_req) && cnt_reg == 3'h0)
    else $error("Counter wrap did not mark an overflow.");

  ovf_flag_a: assert property (
    (s_last_tick and !ctrl_reg[5]) |=> ctrl_reg[1] && wdt_int_req)
    else $error("Runaway flag not set after overflow.");

  int_mode_a: assert property (
    (s_last_tick and !ctrl_reg[5]) |=> !wdt_reset && int_vector == 24'h008000
    ##1 !wdt_int_req)
    else $error("Interrupt mode overflow gave wrong action.");

  rst_mode_a: assert property (
    (s_last_tick and ctrl_reg[5]) |=> s_reset_action ##1 !wdt_reset)
    else $error("Reset mode overflow gave wrong action.");

  clear_cnt_a: assert property (
    clr_op |=> cnt_reg == 3'h0 && !wdt_reset && !wdt_int_req)
    else $error("Bit clear of start did not zero the counter.");

  write_lock_a: assert property (
    (wr_ctrl && started && !hold_enter && !reset_instr && !tk.bt_out)
    |=> ctrl_reg == $past(ctrl_reg))
    else $error("Control write took effect while running.");

  hold_stop_a: assert property (
    (hold_enter && ctrl_reg[3]) |=> !ctrl_reg[0] ##1 cnt_reg == 3'h0)
    else $error("Hold entry did not stop the watchdog.");

  bad_start_a: assert property (
    (wr_ctrl && !started && hwdata[0] && !tk.bt_run) |=> s_reset_action)
    else $error("Start without base timer did not reset.");

  flag_keep_a: assert property (
    (ctrl_reg[4] && !(wr_ctrl && !started)) |=> ctrl_reg[4])
    else $error("Reset flag lost without a software write.");

  no_step_a: assert property (
    (running && !tk.bt_out && !clr_op) |=> cnt_reg == $past(cnt_reg))
    else $error("Counter moved without a base timer tick.");

  stop_zero_a: assert property (
    !started |=> cnt_reg == 3'h0)
    else $error("Counter not held at zero while stopped.");

  action_excl_a: assert property (
    !(wdt_reset && wdt_int_req))
    else $error("Reset and interrupt requested together.");

  irq_raise_a: assert property (
    (wdt_int_req && mask_reg[0]) |-> irq)
    else $error("Unmasked runaway interrupt did not raise irq.");

  flag_rise_a: assert property (
    (!ctrl_reg[1] && !ovf_int && !(wr_ctrl && !started)) |=> !ctrl_reg[1])
    else $error("Runaway flag rose without an overflow.");

  rst_no_int_a: assert property (
    (s_last_tick and ctrl_reg[5]) |=> !wdt_int_req)
    else $error("Reset mode overflow raised an interrupt.");

  vector_keep_a: assert property (
    !ovf_int |=> $stable(int_vector))
    else $error("Vector changed without an overflow.");

  start_lock_a: assert property (
    (started && !hold_enter && !reset_instr && !ovf_rst) |=> started)
    else $error("Start bit dropped while locked.");

  hold_run_a: assert property (
    (hold_enter && !ctrl_reg[3] && started && !reset_instr && !ovf_rst) |=> started)
    else $error("Hold entry stopped the watchdog with hold-stop clear.");

  good_start_a: assert property (
    s_good_start |=> started && !wdt_reset)
    else $error("Proper start did not run the watchdog.");

  flag_set_a: assert property (
    wdt_reset |-> ctrl_reg[4])
    else $error("Watchdog reset without the reset flag.");

  rdata_load_a: assert property (
    (ap_read && haddr == rwd_pkg::ADDR_WDT_CTRL) |=> hrdata[5:0] == $past(ctrl_reg))
    else $error("Control read returned a wrong value.");

  rdata_idle_a: assert property (
    !ap_read |=> hrdata == 32'h0000_0000)
    else $error("Read data not zero outside a read.");

  status_clear_a: assert property (
    (rd_status && int_set == 2'h0) |=> int_status == 2'h0)
    else $error("Status read did not clear the status.");
endmodule // rwd_watchdog
`default_nettype wire

// ### tb/rwd_cpu_model.sv
// Behavioural CPU side: counts watchdog actions and issues hold and reset events.
`timescale 1ns/1ps
`default_nettype none
module rwd_cpu_model (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Watchdog actions.
  input  wire logic        wdt_reset,
  input  wire logic        wdt_int_req,
  input  wire logic [23:0] int_vector,
  // CPU events.
  output logic             hold_enter,
  output logic             reset_instr
);
  int          n_rst = 0;
  int          n_int = 0;
  logic [23:0] vec = 24'h000000;
  initial begin
    hold_enter = 1'b0;
    reset_instr = 1'b0;
  end
  // ****************************************
  // Action capture
  // ****************************************
  always @(posedge clk_sys) begin
    if (reset_n === 1'b1 && wdt_reset === 1'b1) begin
      n_rst <= n_rst + 1;
    end
    if (reset_n === 1'b1 && wdt_int_req === 1'b1) begin
      n_int <= n_int + 1;
      vec <= int_vector;
    end
  end
  // One-cycle hold entry or reset instruction, started just after an edge.
  task automatic pulse(input logic hold);
    if (hold) begin
      hold_enter <= 1'b1;
    end else begin
      reset_instr <= 1'b1;
    end
    @(posedge clk_sys);
    hold_enter <= 1'b0;
    reset_instr <= 1'b0;
  endtask
endmodule // rwd_cpu_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench of the runaway watchdog top.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned LC = 64;
  logic        clk_sys, reset_n, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready;
  logic        hreadyout, hresp, wdt_reset, wdt_int_req, irq, hold_enter, reset_instr;
  logic [31:0] hrdata;
  logic [23:0] int_vector;
  int          n_fail = 0;
  int          n_compared = 0;
  assign hready = hreadyout;
  rwd_watchdog #(.LONG_COUNT(LC)) DUT (
    .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .hold_enter, .reset_instr, .wdt_reset,
    .wdt_int_req, .int_vector, .irq);
  rwd_cpu_model cpu (
    .clk_sys, .reset_n, .wdt_reset, .wdt_int_req, .int_vector, .hold_enter,
    .reset_instr);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      $display("wrong value hready expected 1 seen %b", hready);
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= rwd_pkg::HTRANS_IDLE;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(posedge clk_sys);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic await_evt(input logic r, input int b, lim, output int at);
    at = 0;
    while ((r ? cpu.n_rst : cpu.n_int) == b && at < lim) begin
      @(posedge clk_sys);
      at++;
    end
    if ((r ? cpu.n_rst : cpu.n_int) == b) begin
      n_fail++;
      $display("wrong value action expected pulse seen none");
      wrap_up();
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_badstart;
    int at;
    rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h0);
    rchk("mask", rwd_pkg::ADDR_INT_MASK, 32'h0);
    wr(32'h7f24, 32'h55);
    rchk("unmapped", 32'h7f24, 32'h0);
    chk("resp", 32'h0, {31'h0, hresp});
    for (int b = 0; b < 3; b++) begin
      wr(rwd_pkg::ADDR_BT_CTRL, b);
      at = cpu.n_rst;
      wr(rwd_pkg::ADDR_WDT_CTRL, 32'h01);
      await_evt(1'b1, at, 20, at);
      rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h10);
    end
    rchk("status", rwd_pkg::ADDR_INT_STATUS, 32'h2);
    rchk("status", rwd_pkg::ADDR_INT_STATUS, 32'h0);
    $display("test bad start done");
  endtask
  task automatic t_lock;
    int n;
    wr(rwd_pkg::ADDR_BT_CTRL, 32'h07);
    n = cpu.n_int;
    wr(rwd_pkg::ADDR_WDT_CTRL, 32'h01);
    for (int i = 0; i < 6; i++) begin
      repeat (100) @(posedge clk_sys);
      wr(rwd_pkg::ADDR_WDT_CTRL, 32'h00);
    end
    chk("int count", n, cpu.n_int);
    wr(rwd_pkg::ADDR_WDT_CTRL, 32'h21);
    rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h01);
    $display("test lock and clear done");
  endtask
  task automatic t_period;
    int at;
    int b;
    int nb;
    wr(rwd_pkg::ADDR_INT_MASK, 32'h1);
    for (int c = 0; c < 5; c++) begin
      nb = (c < 2) ? 32 : LC;
      cpu.pulse(1'b0);
      wr(rwd_pkg::ADDR_BT_CTRL, ((c % 4) << 3) | ((c < 4) << 2) | 3);
      b = cpu.n_int;
      wr(rwd_pkg::ADDR_WDT_CTRL, 32'h01);
      await_evt(1'b0, b, 8 * nb + 40, at);
      chk("period", 32'h1, {31'h0, at >= 7 * nb - 4 && at <= 8 * nb + 8});
      chk("irq", 32'h1, {31'h0, irq});
      chk("vector", 32'h8000, {8'h0, cpu.vec});
      rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h03);
      rchk("status", rwd_pkg::ADDR_INT_STATUS, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
    end
    $display("test period and interrupt done");
  endtask
  task automatic t_hold;
    cpu.pulse(1'b0);
    wr(rwd_pkg::ADDR_WDT_CTRL, 32'h01);
    cpu.pulse(1'b1);
    rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h01);
    cpu.pulse(1'b0);
    wr(rwd_pkg::ADDR_WDT_CTRL, 32'h09);
    cpu.pulse(1'b1);
    rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h08);
    $display("test hold done");
  endtask
  task automatic t_rstmode;
    int at;
    int b;
    wr(rwd_pkg::ADDR_BT_CTRL, 32'h03);
    wr(rwd_pkg::ADDR_BT_CLKSEL, 32'h1);
    b = cpu.n_rst;
    wr(rwd_pkg::ADDR_WDT_CTRL, 32'h21);
    await_evt(1'b1, b, 16 * LC + 60, at);
    chk("period", 32'h1, {31'h0, at >= 14 * LC - 6 && at <= 16 * LC + 10});
    rchk("ctrl", rwd_pkg::ADDR_WDT_CTRL, 32'h30);
    rchk("status", rwd_pkg::ADDR_INT_STATUS, 32'h2);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset mode done");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_badstart();
    t_lock();
    t_period();
    t_hold();
    t_rstmode();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
